// File: bench/dpc_debug_port_control_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_debug_port_control_properties (
  input wire logic        hclk, hresetn, hsel, hwrite, hready, debug_halt,
  input wire logic [31:0] haddr, hwdata,
  input wire logic [1:0]  htrans,
  input wire logic        usb_freeze_setting, usb_freeze, scan_port_enable,
  input wire logic        usb_halt_override, serial_port1_halt_override,
  input wire logic        serial_port2_halt_override, sync_port1_halt_override,
  input wire logic        trace_output_enable
);
  // ---------------------------------------------
  // write tracking: data phase flag and its byte
  // ---------------------------------------------
  logic       wp;
  logic [7:0] wb;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wp <= 1'b0;
    else wp <= hsel && hready && htrans[1] && hwrite && haddr[3:0] == 4'h0;
  end
  // data is only meaningful one edge after wp, so capture it every cycle
  always_ff @(posedge hclk) wb <= hwdata[7:0];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  usb_ovr_a: assert property (wp |=> usb_halt_override == wb[7])
    else $error("usb override not loaded");
  ser1_ovr_a: assert property ($past(wp) |-> serial_port1_halt_override == wb[6])
    else $error("port1 override not loaded");
  ser2_ovr_a: assert property (wp ##1 1 |-> serial_port2_halt_override == wb[5])
    else $error("port2 override not loaded");
  sync_ovr_a: assert property (wp |=> sync_port1_halt_override == wb[4])
    else $error("sync port override not loaded");
  scan_en_a: assert property (wp |=> scan_port_enable == wb[3])
    else $error("scan enable not loaded");
  trace_en_a: assert property (wp |=> trace_output_enable == wb[2])
    else $error("trace enable not loaded");
  ctrl_hold_a: assert property (!wp |=> $stable(scan_port_enable)
    && $stable(usb_halt_override)) else $error("control level moved");
  usb_frz_a: assert property (debug_halt [*4] ##0 (usb_freeze_setting
    && !usb_halt_override) |=> usb_freeze) else $error("usb not frozen");
  ovr_run_a: assert property ($past(usb_halt_override) |-> !usb_freeze)
    else $error("overridden usb frozen");
  cover property (wp && hwdata[7]);
  cover property (usb_freeze);
  cover property (wp && !hwdata[3]);
endmodule : dpc_debug_port_control_properties
bind dpc_debug_port_control dpc_debug_port_control_properties i_props (.*);
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import dpc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, halt, scan, trace, resp;
  logic [31:0] haddr, hwdata, hrdata, rd, d, cur;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  fset, ovr, peripheral_freeze_setting;
  int          fails, total_checks, seed;
  dpc_debug_port_control i_dpc_debug_port_control (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(resp), .debug_halt(halt),
    .usb_freeze_setting(fset[3]), .serial_port1_freeze_setting(fset[2]),
    .serial_port2_freeze_setting(fset[1]), .sync_port1_freeze_setting(fset[0]),
    .usb_halt_override(ovr[3]), .serial_port1_halt_override(ovr[2]),
    .serial_port2_halt_override(ovr[1]), .sync_port1_halt_override(ovr[0]),
    .usb_freeze(peripheral_freeze_setting[3]), .serial_port1_freeze(peripheral_freeze_setting[2]),
    .serial_port2_freeze(peripheral_freeze_setting[1]), .sync_port1_freeze(peripheral_freeze_setting[0]),
    .scan_port_enable(scan), .trace_output_enable(trace));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // one single transfer; hready is waited on under a bound in both phases
  task automatic bus(input logic w, input logic [31:0] a, v);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      if (++n > 50) begin
        fails++;
        end_of_test();
      end
      @(posedge hclk);
    end
    htrans <= DPC_HTRANS_IDLE; hwdata <= v;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      if (++n > 99) begin
        fails++;
        end_of_test();
      end
      @(posedge hclk);
    end
    rd = hrdata;
  endtask : bus
  function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
    return {24'h00_0000, v[7:2], 2'b00};
  endfunction : exp_ctrl
  task automatic wr_chk(input logic [31:0] v);
    cur = v;
    bus(1'b1, DPC_CTRL_OFFSET, v);
    bus(1'b0, DPC_CTRL_OFFSET, 32'h0000_0000);
    `CHK(rd, exp_ctrl(v))
    `CHK({ovr, scan, trace}, v[7:2])
  endtask : wr_chk
  initial begin
    seed = 32'h62aa; fails = 0; total_checks = 0; hresetn = 1'b0; hsel = 1'b0;
    haddr = '0; htrans = DPC_HTRANS_IDLE; hwrite = 1'b0; hwdata = '0;
    hsize = DPC_HSIZE_WORD; halt = 1'b0; fset = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({ovr, scan, trace}, DPC_CTRL_RESET)
    `CHK(resp, 1'b0)
    bus(1'b0, DPC_CTRL_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008)
    $display("reset test done");
    wr_chk(32'h0000_00ff);
    wr_chk(32'h0000_0003);
    // random overrides against random halt and freeze settings
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      wr_chk({24'h00_0000, d[7:2], 2'b11});
      fset <= d[11:8]; halt <= d[12];
      repeat (4) @(posedge hclk);
      `CHK(peripheral_freeze_setting, fset & ~cur[7:4] & {4{halt}})
      bus(1'b0, DPC_STAT_OFFSET, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, fset & ~cur[7:4] & {4{halt}}, 3'b000, halt})
    end
    $display("random test done");
    bus(1'b1, 32'h0000_0008, 32'hffff_ffff);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    `CHK(rd, DPC_RSVD_READ)
    bus(1'b0, DPC_CTRL_OFFSET, 32'h0000_0000);
    `CHK(rd, exp_ctrl(cur))
    $display("unmapped test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// File: hw/dpc_debug_port_control.sv
`timescale 1ns/100ps
`default_nettype none

module dpc_debug_port_control
  import dpc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        debug_halt,
  input  wire logic        usb_freeze_setting,
  input  wire logic        serial_port1_freeze_setting,
  input  wire logic        serial_port2_freeze_setting,
  input  wire logic        sync_port1_freeze_setting,
  output logic             usb_halt_override,
  output logic             serial_port1_halt_override,
  output logic             serial_port2_halt_override,
  output logic             sync_port1_halt_override,
  output logic             usb_freeze,
  output logic             serial_port1_freeze,
  output logic             serial_port2_freeze,
  output logic             sync_port1_freeze,
  output logic             scan_port_enable,
  output logic             trace_output_enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                      halt_meta;
    logic                      halt_sync;
    logic                      wr_pend;
    logic [DPC_ADDR_BITS-1:0]  wr_addr;
    logic [5:0]                ctrl;
    logic [DPC_NUM_PERIPH-1:0] freeze;
    logic [31:0]               rdata;
  } dpc_state_s;

  dpc_state_s state;
  dpc_state_s next_state;

  logic [DPC_NUM_PERIPH-1:0] freeze_setting;
  logic [DPC_NUM_PERIPH-1:0] override_bits;
  logic [DPC_NUM_PERIPH-1:0] next_freeze;
  logic                      take;
  logic                      rd_take;
  logic [DPC_ADDR_BITS-1:0]  addr_idx;
  logic                      wr_ctrl;
  logic [5:0]                wr_field;
  logic [5:0]                ctrl_now;
  logic [31:0]               read_word;

  assign freeze_setting = {usb_freeze_setting, serial_port1_freeze_setting,
                           serial_port2_freeze_setting,
                           sync_port1_freeze_setting};
  // ctrl[5:2] hold bits 7..4 of the word: usb, port1, port2, sync1
  assign override_bits  = state.ctrl[5:2];

  // ---------------------------------------------------------------
  // freeze gates, one per peripheral
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DPC_NUM_PERIPH; gi++) begin : g_gate
      dpc_freeze_gate u_gate (
        .halt_sync      (state.halt_sync),
        .freeze_setting (freeze_setting[gi]),
        .halt_override  (override_bits[gi]),
        .freeze         (next_freeze[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // a transfer is taken only once the previous one has completed;
  // hsize is not decoded, every access is treated as a whole word
  assign take     = hsel & hready & htrans[1];
  assign rd_take  = take & ~hwrite;
  assign addr_idx = haddr[DPC_ADDR_BITS-1:0];

  // the control write lands at the end of its data phase
  assign wr_ctrl  = state.wr_pend &
                    (state.wr_addr == DPC_CTRL_OFFSET[DPC_ADDR_BITS-1:0]);

  // reserved bits 31..8 and 1..0 are dropped on the way in, so what
  // software puts there cannot disturb the stored field
  assign wr_field = hwdata[DPC_USB_BIT:DPC_TRACE_BIT];

  // a read whose address phase overlaps the data phase of a control
  // write must already see the new word, so the write is forwarded
  assign ctrl_now = wr_ctrl ? wr_field : state.ctrl;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // reserved bits read zero; software ignores them anyway
  always_comb begin
    read_word = DPC_RSVD_READ;
    case (addr_idx)
      DPC_CTRL_OFFSET[DPC_ADDR_BITS-1:0]: begin
        read_word[DPC_USB_BIT:DPC_TRACE_BIT] = ctrl_now;
      end
      DPC_STAT_OFFSET[DPC_ADDR_BITS-1:0]: begin
        read_word[DPC_HALT_BIT]              = state.halt_sync;
        read_word[DPC_USB_BIT:DPC_SYNC1_BIT] = state.freeze;
      end
      default: begin
        // unmapped offsets read zero and ignore writes
        read_word = DPC_RSVD_READ;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // usage notes
  // ---------------------------------------------------------------
  // the slave never stretches a transfer: hreadyout is tied high and
  // the response is always okay, so a master sees one data phase per
  // access. read data is registered at the address phase and stands
  // until the next read is taken.
  //
  // only the low address bits are decoded, so the two words repeat
  // through the whole window that the fabric hands to this slave.
  // a narrow write is treated as a full word write: masters must use
  // word accesses, or they will clear neighbouring fields.
  //
  // the halt input comes from the core's debug logic in another clock
  // domain and passes two flops before anything reads it; a freeze
  // therefore follows the halt by three clocks. the freeze settings
  // and overrides come from this clock and add one flop only.
  //
  // the freeze outputs are levels. a peripheral that samples them on
  // its own clock must synchronise them itself; they change rarely,
  // so two flops on the far side are enough.
  //
  // the scan port enable comes out of reset set, so a debugger can
  // attach before software runs. software that clears it shuts the
  // scan port until the next reset or rewrite.
  //
  // status bits are read only; a write to the status word is ignored.

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // writes land one cycle after the address phase, with hwdata valid
  always_comb begin
    next_state           = state;
    next_state.halt_meta = debug_halt;
    next_state.halt_sync = state.halt_meta;
    next_state.freeze    = next_freeze;
    next_state.wr_pend   = take & hwrite;
    next_state.wr_addr   = addr_idx;
    next_state.ctrl      = ctrl_now;
    if (rd_take) begin
      next_state.rdata = read_word;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= '0;
      state.ctrl      <= DPC_CTRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops except hreadyout and hresp, which are tied
  // ---------------------------------------------------------------
  assign hrdata                     = state.rdata;
  assign hreadyout                  = 1'b1;  // zero wait states
  assign hresp                      = 1'b0;  // always okay
  assign usb_halt_override          = state.ctrl[5];
  assign serial_port1_halt_override = state.ctrl[4];
  assign serial_port2_halt_override = state.ctrl[3];
  assign sync_port1_halt_override   = state.ctrl[2];
  assign scan_port_enable           = state.ctrl[1];
  assign trace_output_enable        = state.ctrl[0];
  assign usb_freeze                 = state.freeze[3];
  assign serial_port1_freeze        = state.freeze[2];
  assign serial_port2_freeze        = state.freeze[1];
  assign sync_port1_freeze          = state.freeze[0];

endmodule : dpc_debug_port_control

`default_nettype wire

// File: hw/dpc_freeze_gate.sv
`timescale 1ns/100ps
`default_nettype none

// one peripheral's freeze decision: the override, when set, keeps the
// peripheral running even while the core is halted in debug mode
module dpc_freeze_gate (
  input  wire logic halt_sync,
  input  wire logic freeze_setting,
  input  wire logic halt_override,
  output logic      freeze
);

  assign freeze = halt_sync & freeze_setting & ~halt_override;

endmodule : dpc_freeze_gate

`default_nettype wire

// File: hw/dpc_pkg.sv
package dpc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] DPC_CTRL_OFFSET  = 32'h0000_0000;
  localparam logic [31:0] DPC_STAT_OFFSET  = 32'h0000_0004;
  localparam int          DPC_ADDR_BITS    = 4;

  // ---------------------------------------------------------------
  // field positions of the control and status words
  // ---------------------------------------------------------------
  localparam int          DPC_USB_BIT      = 7;
  localparam int          DPC_SER1_BIT     = 6;
  localparam int          DPC_SER2_BIT     = 5;
  localparam int          DPC_SYNC1_BIT    = 4;
  localparam int          DPC_SCAN_BIT     = 3;
  localparam int          DPC_TRACE_BIT    = 2;
  localparam int          DPC_HALT_BIT     = 0;
  localparam int          DPC_HOLD_BIT     = 1;
  localparam int          DPC_NUM_PERIPH   = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  // stored field holds word bits 7..2, so scan enable (word bit 3) is
  // field bit 1: the word reads 0x08 after reset
  localparam logic [5:0]  DPC_CTRL_RESET   = 6'h02;
  localparam logic [31:0] DPC_RSVD_READ    = 32'h0000_0000;
  localparam logic [1:0]  DPC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  DPC_HTRANS_IDLE  = 2'h0;
  localparam logic [2:0]  DPC_HSIZE_WORD   = 3'h2;

endpackage : dpc_pkg
